// file: evp_pkg.sv
package evp_pkg;

  // widths
  localparam int EXC_W   = 6;
  localparam int PRIO_W  = 3;
  localparam int EPRIO_W = 4;

  // vector base after reset and the bits software may set
  localparam logic [31:0] VEC_BASE_RST  = 32'h0000_0000;
  localparam logic [31:0] VEC_BASE_MASK = 32'h3FFF_FF00;
  localparam logic [31:0] VEC_ENTRY_SP  = 32'h0000_0000;
  localparam logic [31:0] VEC_ENTRY_RST = 32'h0000_0004;

  // register offsets
  localparam logic [7:0] ADDR_VEC_BASE = 8'h00;
  localparam logic [7:0] ADDR_SYS_PEND = 8'h04;
  localparam logic [7:0] ADDR_IRQ_PEND = 8'h08;
  localparam logic [7:0] ADDR_STATUS   = 8'h0C;
  localparam logic [7:0] ADDR_SYS_PRIO = 8'h10;
  localparam logic [7:0] ADDR_IRQ_PRIO = 8'h20;
  localparam logic [7:0] ADDR_IRQ_LAST = 8'h2C;

  // software set bits in the system pending register
  localparam int SWP_PENDABLE_SERVICE_REQUEST_BIT  = 0;
  localparam int SWP_SYSTICK_BIT = 1;
  localparam int SWP_NMI_BIT     = 2;

  // status register field positions
  localparam int ST_RUN_NUM_LSB  = 0;
  localparam int ST_RUN_PRIO_LSB = 8;
  localparam int ST_WIN_NUM_LSB  = 16;
  localparam int ST_REQ_BIT      = 24;

  // exception numbers
  localparam int EXC_SP      = 0;
  localparam int EXC_RESET   = 1;
  localparam int EXC_NMI     = 2;
  localparam int EXC_HARD    = 3;
  localparam int EXC_MEM     = 4;
  localparam int EXC_BUS     = 5;
  localparam int EXC_USAGE   = 6;
  localparam int EXC_SVC     = 11;
  localparam int EXC_DBGMON  = 12;
  localparam int EXC_PENDABLE_SERVICE_REQUEST  = 14;
  localparam int EXC_SYSTICK = 15;
  localparam int IRQ_BASE    = 16;

  // effective priority: fixed -2 and -1 map to 0 and 1, level p maps to p+2
  localparam logic [3:0] EPRIO_NMI     = 4'h0;
  localparam logic [3:0] EPRIO_HARD    = 4'h1;
  localparam logic [3:0] EPRIO_CFG_OFS = 4'h2;
  localparam logic [3:0] EPRIO_NONE    = 4'hF;
  localparam logic [2:0] PRIO_RST      = 3'h0;

  // configurable system exceptions, one priority slot each
  localparam int NUM_SYS_CFG = 7;
  localparam int SYS_CFG_EXC [NUM_SYS_CFG] = '{EXC_MEM, EXC_BUS, EXC_USAGE, EXC_SVC,
                                                EXC_DBGMON, EXC_PENDABLE_SERVICE_REQUEST, EXC_SYSTICK};

  // interrupt lines that are never implemented
  localparam logic [29:0] IRQ_RESERVED = 30'h0C00_2200;

  // slot of a configurable system exception, -1 if none
  function automatic int sys_slot(input int exc);
    int slot;
    slot = -1;
    for (int s = 0; s < NUM_SYS_CFG; s++) begin
      if (SYS_CFG_EXC[s] == exc) begin
        slot = s;
      end
    end
    return slot;
  endfunction

endpackage

// file: evp_sync3.sv
`timescale 1ns/1ns
module evp_sync3 #(
  parameter int WIDTH = 31
) (
  // clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_clk_en,
  // asynchronous levels in, filtered levels out
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_level
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } evp_sync_s;

  evp_sync_s st;
  evp_sync_s next_st;

  initial begin
    if (WIDTH < 1) begin
      $error("evp_sync3: WIDTH must be at least 1");
    end
  end

  // three stages; a change is taken once stages two and three agree
  always_comb begin
    next_st    = st;
    next_st.s1 = i_async;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.q  = (~(st.s2 ^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.q);
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else if (i_clk_en) begin
      st <= next_st;
    end
  end

  assign o_level = st.q;

endmodule

// file: evp_arbiter.sv
`timescale 1ns/1ns
module evp_arbiter #(
  parameter int N = 46
) (
  // candidates and their effective priorities
  input  wire logic [N-1:0]      i_req,
  input  wire logic [N-1:0][3:0] i_prio,
  // winner
  output logic                   o_found,
  output logic [5:0]             o_num,
  output logic [3:0]             o_prio
);

  initial begin
    if (N < 1 || N > 64) begin
      $error("evp_arbiter: N must be 1 to 64");
    end
  end

  // scan downward so the lowest number wins among equal priorities
  always_comb begin
    o_found = 1'b0;
    o_num   = 6'h00;
    o_prio  = evp_pkg::EPRIO_NONE;
    for (int i = N - 1; i >= 0; i--) begin
      if (i_req[i] && (!o_found || i_prio[i] <= o_prio)) begin
        o_found = 1'b1;
        o_num   = 6'(i);
        o_prio  = i_prio[i];
      end
    end
  end

endmodule

// file: evp_vector_prio.sv
`timescale 1ns/1ns
// Functional notes
// - entry zero is stack pointer, others handlers
// - vector base is zero after reset
// - only privileged writes move vector base
// - vector base spans 0x0 to 0x3FFFFF00
// - lower priority value is more urgent
// - reset, hard fault, NMI fixed; others configurable
// - configurable priorities reset to zero
// - configurable priorities are 0 to 7
// - fixed negative priorities always win arbitration
// - equal priority: lowest exception number first
// - strictly more urgent pending exception preempts handler
// - equal priority never preempts running handler
// - non-preempting exception stays pending
// - line n is exception n+16, offset 4n+0x40
// - hard, memory, usage, bus are faults
// - NMI, pendable_service_request, svc, tick, faults are system
// - NMI always enabled, fixed priority -2
// - hard fault fixed priority -1
module evp_vector_prio #(
  parameter int NUM_IRQ = 30
) (
  // clock, reset, enable
  input  wire logic               i_sys_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_clk_en,
  // register port
  input  wire logic [7:0]         i_addr,
  input  wire logic [31:0]        i_wdata,
  input  wire logic               i_we,
  input  wire logic               i_re,
  input  wire logic               i_priv,
  output logic      [31:0]        o_rdata,
  // exception sources
  input  wire logic [NUM_IRQ-1:0] i_peripheral_irq_line,
  input  wire logic               i_nmi,
  input  wire logic [3:0]         i_fault_pulse,
  input  wire logic               i_svc_pulse,
  input  wire logic               i_dbgmon_pulse,
  input  wire logic               i_systick_pulse,
  // core handshake
  output logic                    o_exc_req,
  output logic      [5:0]         o_exc_num,
  output logic      [31:0]        o_vector_addr,
  output logic                    o_preempt,
  output logic                    o_is_fault,
  output logic                    o_is_system,
  output logic      [31:0]        o_vector_base,
  output logic      [31:0]        o_sp_fetch_addr,
  output logic      [31:0]        o_reset_fetch_addr,
  input  wire logic               i_exc_ack,
  input  wire logic               i_exc_return,
  input  wire logic [5:0]         i_ret_num
);

  localparam int NUM_EXC = evp_pkg::IRQ_BASE + NUM_IRQ;

  typedef struct packed {
    logic [31:0]                vec_base;
    logic [6:0][2:0]            sys_prio;
    logic [NUM_IRQ-1:0][2:0]    irq_prio;
    logic [NUM_EXC-1:0]         pend;
    logic [NUM_EXC-1:0]         active;
    logic [31:0]                rdata;
  } evp_state_s;

  evp_state_s               st;
  evp_state_s               next_st;
  logic [NUM_EXC-1:0][3:0]  eprio;
  logic [NUM_IRQ-1:0]       irq_lvl;
  logic                     nmi_lvl;
  logic                     win_found;
  logic [5:0]               win_num;
  logic [3:0]               win_prio;
  logic                     run_found;
  logic [5:0]               run_num;
  logic [3:0]               run_prio;

  initial begin
    if (NUM_IRQ < 1 || NUM_IRQ > 30) begin
      $error("evp_vector_prio: NUM_IRQ must be 1 to 30");
    end
  end

  // pin level sources cross into the clock domain
  evp_sync3 #(
    .WIDTH (NUM_IRQ + 1)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_clk_en  (i_clk_en),
    .i_async   ({i_nmi, i_peripheral_irq_line}),
    .o_level   ({nmi_lvl, irq_lvl})
  );

  // effective priority of every exception number
  for (genvar e = 0; e < NUM_EXC; e++) begin : g_eprio
    localparam int SLOT = evp_pkg::sys_slot(e);
    if (e == evp_pkg::EXC_NMI) begin : g_nmi
      assign eprio[e] = evp_pkg::EPRIO_NMI;
    end else if (e == evp_pkg::EXC_HARD) begin : g_hard
      assign eprio[e] = evp_pkg::EPRIO_HARD;
    end else if (e >= evp_pkg::IRQ_BASE) begin : g_irq
      assign eprio[e] = evp_pkg::EPRIO_CFG_OFS + {1'b0, st.irq_prio[e - evp_pkg::IRQ_BASE]};
    end else if (SLOT >= 0) begin : g_sys
      assign eprio[e] = evp_pkg::EPRIO_CFG_OFS + {1'b0, st.sys_prio[SLOT]};
    end else begin : g_none
      assign eprio[e] = evp_pkg::EPRIO_NONE;
    end
  end

  // most urgent pending exception
  evp_arbiter #(
    .N (NUM_EXC)
  ) u_pend_arb (
    .i_req   (st.pend),
    .i_prio  (eprio),
    .o_found (win_found),
    .o_num   (win_num),
    .o_prio  (win_prio)
  );

  // running handler is the most urgent active exception
  evp_arbiter #(
    .N (NUM_EXC)
  ) u_run_arb (
    .i_req   (st.active),
    .i_prio  (eprio),
    .o_found (run_found),
    .o_num   (run_num),
    .o_prio  (run_prio)
  );

  // next state: pending, active, registers, read data
  always_comb begin
    logic [NUM_EXC-1:0] set_p;
    logic [NUM_EXC-1:0] clr_p;
    logic [31:0]        rd;
    int                 k;
    next_st = st;
    set_p   = '0;
    clr_p   = '0;
    rd      = 32'h0000_0000;
    k       = 0;
    // hardware set sources
    set_p[evp_pkg::EXC_NMI]     = nmi_lvl;
    set_p[evp_pkg::EXC_HARD]    = i_fault_pulse[0];
    set_p[evp_pkg::EXC_MEM]     = i_fault_pulse[1];
    set_p[evp_pkg::EXC_BUS]     = i_fault_pulse[2];
    set_p[evp_pkg::EXC_USAGE]   = i_fault_pulse[3];
    set_p[evp_pkg::EXC_SVC]     = i_svc_pulse;
    set_p[evp_pkg::EXC_DBGMON]  = i_dbgmon_pulse;
    set_p[evp_pkg::EXC_SYSTICK] = i_systick_pulse;
    set_p[NUM_EXC-1:evp_pkg::IRQ_BASE] = irq_lvl & ~evp_pkg::IRQ_RESERVED[NUM_IRQ-1:0];
    // software set of system exceptions
    if (i_we && i_addr == evp_pkg::ADDR_SYS_PEND) begin
      set_p[evp_pkg::EXC_PENDABLE_SERVICE_REQUEST]  = set_p[evp_pkg::EXC_PENDABLE_SERVICE_REQUEST] | i_wdata[evp_pkg::SWP_PENDABLE_SERVICE_REQUEST_BIT];
      set_p[evp_pkg::EXC_SYSTICK] = set_p[evp_pkg::EXC_SYSTICK] | i_wdata[evp_pkg::SWP_SYSTICK_BIT];
      set_p[evp_pkg::EXC_NMI]     = set_p[evp_pkg::EXC_NMI] | i_wdata[evp_pkg::SWP_NMI_BIT];
    end
    // acceptance moves the offered exception from pending to active
    if (i_exc_ack && o_exc_req) begin
      clr_p[o_exc_num] = 1'b1;
    end
    next_st.pend = (st.pend & ~clr_p) | set_p;
    if (i_exc_return && i_ret_num < 6'(NUM_EXC)) begin
      next_st.active[i_ret_num] = 1'b0;
    end
    if (i_exc_ack && o_exc_req) begin
      next_st.active[o_exc_num] = 1'b1;
    end
    // register writes
    if (i_we) begin
      if (i_addr == evp_pkg::ADDR_VEC_BASE && i_priv) begin
        next_st.vec_base = i_wdata & evp_pkg::VEC_BASE_MASK;
      end
      if (i_addr == evp_pkg::ADDR_SYS_PRIO) begin
        for (int s = 0; s < evp_pkg::NUM_SYS_CFG; s++) begin
          next_st.sys_prio[s] = i_wdata[4*s +: 3];
        end
      end
      if (i_addr >= evp_pkg::ADDR_IRQ_PRIO && i_addr <= evp_pkg::ADDR_IRQ_LAST && i_addr[1:0] == 2'b00) begin
        for (int j = 0; j < 8; j++) begin
          k = 8 * int'(i_addr[3:2]) + j;
          if (k < NUM_IRQ) begin
            next_st.irq_prio[k] = i_wdata[4*j +: 3];
          end
        end
      end
    end
    // read data for the next cycle only
    if (i_re) begin
      if (i_addr == evp_pkg::ADDR_VEC_BASE) begin
        rd = st.vec_base;
      end else if (i_addr == evp_pkg::ADDR_SYS_PEND) begin
        rd[15:0] = st.pend[15:0];
      end else if (i_addr == evp_pkg::ADDR_IRQ_PEND) begin
        rd[NUM_IRQ-1:0] = st.pend[NUM_EXC-1:evp_pkg::IRQ_BASE];
      end else if (i_addr == evp_pkg::ADDR_STATUS) begin
        rd[evp_pkg::ST_RUN_NUM_LSB +: 6]  = run_found ? run_num : 6'h00;
        rd[evp_pkg::ST_RUN_PRIO_LSB +: 4] = run_prio;
        rd[evp_pkg::ST_WIN_NUM_LSB +: 6]  = win_num;
        rd[evp_pkg::ST_REQ_BIT]           = o_exc_req;
      end else if (i_addr == evp_pkg::ADDR_SYS_PRIO) begin
        for (int s = 0; s < evp_pkg::NUM_SYS_CFG; s++) begin
          rd[4*s +: 3] = st.sys_prio[s];
        end
      end else if (i_addr >= evp_pkg::ADDR_IRQ_PRIO && i_addr <= evp_pkg::ADDR_IRQ_LAST
                   && i_addr[1:0] == 2'b00) begin
        for (int j = 0; j < 8; j++) begin
          k = 8 * int'(i_addr[3:2]) + j;
          if (k < NUM_IRQ) begin
            rd[4*j +: 3] = st.irq_prio[k];
          end
        end
      end
    end
    next_st.rdata = rd;
  end

  // state register
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st          <= '0;
      st.vec_base <= evp_pkg::VEC_BASE_RST;
      st.sys_prio <= {evp_pkg::NUM_SYS_CFG{evp_pkg::PRIO_RST}};
      st.irq_prio <= {NUM_IRQ{evp_pkg::PRIO_RST}};
    end else if (i_clk_en) begin
      st <= next_st;
    end
  end

  // offer the winner only when strictly more urgent than the running handler
  assign o_exc_req     = win_found && (win_prio < run_prio);
  assign o_exc_num     = win_num;
  assign o_vector_addr = st.vec_base + {24'h00_0000, win_num, 2'b00};
  assign o_preempt     = o_exc_req && run_found;

  // handler class of the offered exception
  assign o_is_fault  = (win_num >= 6'(evp_pkg::EXC_HARD)) && (win_num <= 6'(evp_pkg::EXC_USAGE));
  assign o_is_system = o_is_fault || win_num == 6'(evp_pkg::EXC_NMI)
                       || win_num == 6'(evp_pkg::EXC_SVC) || win_num == 6'(evp_pkg::EXC_PENDABLE_SERVICE_REQUEST)
                       || win_num == 6'(evp_pkg::EXC_SYSTICK);

  // table fetch addresses and read port
  assign o_vector_base      = st.vec_base;
  assign o_sp_fetch_addr    = st.vec_base + evp_pkg::VEC_ENTRY_SP;
  assign o_reset_fetch_addr = st.vec_base + evp_pkg::VEC_ENTRY_RST;
  assign o_rdata            = st.rdata;

  // check helpers: equal-priority tie order, and any active handler as urgent as the winner
  logic tie_bad;
  logic pre_bad;
  always_comb begin
    tie_bad = 1'b0;
    pre_bad = 1'b0;
    for (int i = 0; i < NUM_EXC; i++) begin
      if (st.pend[i] && 6'(i) < win_num && eprio[i] == win_prio) begin
        tie_bad = 1'b1;
      end
      if (st.active[i] && eprio[i] <= win_prio) begin
        pre_bad = 1'b1;
      end
    end
  end

  AST_VEC_ADDR: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_exc_req |-> o_vector_addr == o_vector_base + {24'h00_0000, o_exc_num, 2'b00})
    else $error("vector address does not match exception number");

  AST_BASE_RANGE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (o_vector_base & ~evp_pkg::VEC_BASE_MASK) == 32'h0000_0000)
    else $error("vector base outside supported range");

  AST_PRIV_ONLY: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_we && !i_priv && i_addr == evp_pkg::ADDR_VEC_BASE) |=> $stable(o_vector_base))
    else $error("unprivileged write moved vector base");

  AST_NMI_WINS: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (st.pend[evp_pkg::EXC_NMI] && !st.active[evp_pkg::EXC_NMI]) |-> (o_exc_req && o_exc_num == 6'h02))
    else $error("pending nmi not offered first");

  AST_STRICT_PREEMPT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (win_found && win_prio < run_prio) |-> o_exc_req)
    else $error("more urgent exception not offered");

  AST_EQUAL_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_exc_req |-> !pre_bad)
    else $error("equal or lower priority preempted handler");

  AST_STAYS_PENDING: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_clk_en && win_found && !(i_exc_ack && o_exc_req)) |=> st.pend[$past(win_num)])
    else $error("unserviced exception lost its pending state");

  AST_TIE_LOW: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    win_found |-> !tie_bad)
    else $error("tie not broken toward lowest number");

  AST_RESERVED: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (st.pend[NUM_EXC-1:evp_pkg::IRQ_BASE] & evp_pkg::IRQ_RESERVED[NUM_IRQ-1:0]) == '0)
    else $error("reserved line became pending");

  AST_CFG_RANGE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (o_exc_req && o_exc_num > 6'h03) |-> (win_prio >= evp_pkg::EPRIO_CFG_OFS && win_prio <= 4'h9))
    else $error("configurable priority outside eight levels");

  AST_ACK_ACTIVE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_clk_en && i_exc_ack && o_exc_req) |=> st.active[$past(o_exc_num)])
    else $error("accepted exception did not become active");

  AST_REQ_PENDING: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_exc_req |-> st.pend[o_exc_num])
    else $error("offered exception is not pending");

  AST_FAULT_SYSTEM: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_is_fault |-> o_is_system)
    else $error("fault exception not classed as system");

  AST_SWP_PENDABLE_SERVICE_REQUEST: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_clk_en && i_we && i_addr == evp_pkg::ADDR_SYS_PEND && i_wdata[evp_pkg::SWP_PENDABLE_SERVICE_REQUEST_BIT])
    |=> st.pend[evp_pkg::EXC_PENDABLE_SERVICE_REQUEST])
    else $error("software set of pendable request lost");

  AST_NMI_ENABLED: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_clk_en && nmi_lvl) |=> st.pend[evp_pkg::EXC_NMI])
    else $error("nmi level did not pend");

  AST_NO_SP_ENTRY: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_exc_req |-> o_exc_num > 6'h01)
    else $error("stack pointer or reset entry offered as handler");

  AST_IRQ_LEVEL: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_clk_en && irq_lvl[0]) |=> st.pend[evp_pkg::IRQ_BASE])
    else $error("line zero did not pend exception sixteen");

  COV_PREEMPT: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) o_preempt && i_exc_ack);
  COV_NMI: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) o_exc_req && o_exc_num == 6'h02);
  COV_HELD: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) run_found && win_found && !o_exc_req);
  COV_RELOC: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) o_vector_base != 32'h0000_0000);

endmodule

// file: evp_core_model.sv
`timescale 1ns/1ns
module evp_core_model (
  // clock
  input  wire logic       i_sys_clk,
  // bench control
  input  wire logic       i_take,
  input  wire logic [1:0] i_delay,
  // offered exception
  input  wire logic       i_exc_req,
  input  wire logic [5:0] i_exc_num,
  // core answer
  output logic            o_exc_ack,
  output logic            o_taken,
  output logic [5:0]      o_taken_num
);
  int   wait_n = 0;
  logic armed  = 1'b0;

  initial begin
    o_exc_ack   = 1'b0;
    o_taken     = 1'b0;
    o_taken_num = 6'h00;
  end

  // arm on request, ack only while offered, after a chosen delay
  always @(posedge i_sys_clk) begin
    o_exc_ack <= 1'b0;
    o_taken   <= 1'b0;
    if (i_take && !armed) begin
      armed  <= 1'b1;
      wait_n <= int'(i_delay);
    end else if (armed && i_exc_req === 1'b1) begin
      if (wait_n == 0) begin
        o_exc_ack   <= 1'b1; // one-cycle ack pulse
        o_taken     <= 1'b1;
        o_taken_num <= i_exc_num;
        armed       <= 1'b0;
      end else begin
        wait_n <= wait_n - 1;
      end
    end
  end
endmodule

// file: test_exception_vector_priority_logic.sv
`timescale 1ns/1ns
module test_exception_vector_priority_logic;
  logic        i_sys_clk = 1'b0;
  logic        i_rst_n, i_clk_en, i_we, i_re, i_priv, i_nmi, i_svc_pulse, i_dbgmon_pulse;
  logic        i_systick_pulse, i_exc_return, take_req, exc_ack, taken;
  logic        o_exc_req, o_preempt, o_is_fault, o_is_system;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata, base, rnd, o_rdata, o_vector_addr, o_vector_base, o_sp_fetch_addr, o_reset_fetch_addr;
  logic [29:0] lines;
  logic [3:0]  i_fault_pulse;
  logic [5:0]  i_ret_num, o_exc_num, taken_num;
  logic [1:0]  delay;
  int          fails = 0;
  int          n_compared = 0;
  int          eprio[46];
  bit          pend[46];
  bit          act[46];

  // 10 MHz clock
  always #50 i_sys_clk = ~i_sys_clk;

  evp_vector_prio #(.NUM_IRQ(30)) dut_u (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_we(i_we), .i_re(i_re), .i_priv(i_priv), .o_rdata(o_rdata), .i_peripheral_irq_line(lines),
    .i_nmi(i_nmi), .i_fault_pulse(i_fault_pulse), .i_svc_pulse(i_svc_pulse), .i_dbgmon_pulse(i_dbgmon_pulse),
    .i_systick_pulse(i_systick_pulse), .o_exc_req(o_exc_req), .o_exc_num(o_exc_num),
    .o_vector_addr(o_vector_addr), .o_preempt(o_preempt), .o_is_fault(o_is_fault), .o_is_system(o_is_system),
    .o_vector_base(o_vector_base), .o_sp_fetch_addr(o_sp_fetch_addr), .o_reset_fetch_addr(o_reset_fetch_addr),
    .i_exc_ack(exc_ack), .i_exc_return(i_exc_return), .i_ret_num(i_ret_num));

  evp_core_model core_u (
    .i_sys_clk(i_sys_clk), .i_take(take_req), .i_delay(delay), .i_exc_req(o_exc_req), .i_exc_num(o_exc_num),
    .o_exc_ack(exc_ack), .o_taken(taken), .o_taken_num(taken_num));

  task automatic final_report();
    if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // model: most urgent pending, lowest number on ties
  function automatic int win();
    int w = -1;
    for (int i = 0; i < 46; i++) if (pend[i] && (w < 0 || eprio[i] < eprio[w])) w = i;
    return w;
  endfunction

  function automatic int run();
    int r = 15;
    for (int i = 0; i < 46; i++) if (act[i] && eprio[i] < r) r = eprio[i];
    return r;
  endfunction

  task automatic check_exc();
    int   w;
    logic req;
    w   = win();
    req = (w >= 0) && (eprio[w] < run());
    chk("exc_req", 32'(o_exc_req), 32'(req));
    chk("preempt", 32'(o_preempt), 32'(req && run() != 15));
    if (w >= 0) begin
      chk("exc_num", 32'(o_exc_num), w);
      chk("vector_addr", o_vector_addr, base + 32'(4 * w));
      chk("is_fault", 32'(o_is_fault), 32'(w >= 3 && w <= 6));
      chk("is_system", 32'(o_is_system), 32'(w inside {2, 3, 4, 5, 6, 11, 14, 15}));
    end
  endtask

  task automatic settle();
    repeat (2) @(posedge i_sys_clk);
    #1;
    check_exc();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic p);
    @(posedge i_sys_clk);
    i_we    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    i_priv  <= p;
    @(posedge i_sys_clk);
    i_we <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_sys_clk);
    i_re   <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_re <= 1'b0;
    #1;
    chk(what, o_rdata, exp);
  endtask

  // raise a line (30 = nmi pin) long enough to pass the synchroniser
  task automatic pulse(input int n);
    @(posedge i_sys_clk);
    if (n == 30) i_nmi <= 1'b1;
    else lines[n] <= 1'b1;
    repeat (6) @(posedge i_sys_clk);
    if (n == 30) i_nmi <= 1'b0;
    else lines[n] <= 1'b0;
    repeat (6) @(posedge i_sys_clk);
    if (n == 30) pend[2] = 1;
    else if (!(n inside {9, 13, 26, 27})) pend[n + 16] = 1;
  endtask

  task automatic fire(input int k);
    int fexc[7] = '{3, 4, 5, 6, 11, 12, 15};
    @(posedge i_sys_clk);
    if (k < 4) i_fault_pulse <= 4'(1 << k);
    else if (k == 4) i_svc_pulse <= 1'b1;
    else if (k == 5) i_dbgmon_pulse <= 1'b1;
    else i_systick_pulse <= 1'b1;
    @(posedge i_sys_clk);
    {i_fault_pulse, i_svc_pulse, i_dbgmon_pulse, i_systick_pulse} <= 7'h00;
    pend[fexc[k]] = 1;
  endtask

  task automatic take(input int n);
    int k;
    @(posedge i_sys_clk);
    take_req <= 1'b1;
    delay    <= 2'($urandom);
    @(posedge i_sys_clk);
    take_req <= 1'b0;
    k = 0;
    do begin
      @(posedge i_sys_clk);
      #1;
      k++;
    end while (taken !== 1'b1 && k < 20);
    if (k >= 20) begin
      fails++;
      final_report();
    end
    chk("taken_num", 32'(taken_num), n);
    pend[n] = 0;
    act[n]  = 1;
    settle();
  endtask

  task automatic ret(input int n);
    @(posedge i_sys_clk);
    i_exc_return <= 1'b1;
    i_ret_num    <= 6'(n);
    @(posedge i_sys_clk);
    i_exc_return <= 1'b0;
    act[n] = 0;
    settle();
  endtask

  // main sequence
  initial begin
    logic [7:0] pa[5];
    int lst[7];
    pa = '{8'h10, 8'h20, 8'h24, 8'h28, 8'h2C};
    {i_rst_n, i_we, i_re, i_priv, i_nmi, i_svc_pulse, i_dbgmon_pulse} = 7'h00;
    {i_systick_pulse, i_exc_return, take_req, delay, i_fault_pulse} = 9'h000;
    {i_addr, i_wdata, lines, i_ret_num, base} = 108'h0;
    i_clk_en = 1'b1;
    void'($urandom(70917));
    for (int i = 0; i < 46; i++) eprio[i] = 2;
    eprio[2] = 0;
    eprio[3] = 1;
    repeat (4) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    #1;
    chk("sp_fetch", o_sp_fetch_addr, 32'h0000_0000);
    chk("reset_fetch", o_reset_fetch_addr, 32'h0000_0004);
    rd_chk("vec_base", 8'h00, 32'h0000_0000);
    foreach (pa[i]) rd_chk("prio_reset", pa[i], 32'h0000_0000);
    // relocation, privilege and range
    rnd = ($urandom & 32'h3FFF_FF00) | 32'h0000_0100;
    wr(8'h00, rnd, 1'b0);
    rd_chk("vec_base_unpriv", 8'h00, 32'h0000_0000);
    wr(8'h00, 32'hFFFF_FFFF, 1'b1);
    rd_chk("vec_base_max", 8'h00, 32'h3FFF_FF00);
    wr(8'h00, rnd, 1'b1);
    base = rnd;
    rd_chk("vec_base", 8'h00, base);
    chk("vector_base", o_vector_base, base);
    chk("sp_fetch", o_sp_fetch_addr, base);
    chk("reset_fetch", o_reset_fetch_addr, base + 32'h0000_0004);
    // a write while the clock enable is low must not land
    @(posedge i_sys_clk);
    i_clk_en <= 1'b0;
    wr(8'h00, 32'h0000_0100, 1'b1);
    i_clk_en <= 1'b1;
    #1;
    chk("vector_base_frozen", o_vector_base, base);
    rd_chk("unmapped", 8'hF0, 32'h0000_0000);
    wr(8'h20, 32'hFFFF_FFFF, 1'b1);
    rd_chk("prio_range", 8'h20, 32'h7777_7777);
    wr(8'h20, 32'h0000_0000, 1'b1);
    // line to vector mapping, reserved lines stay silent
    lst = '{0, 29, 9, 13, 26, 27, int'($urandom % 30)};
    foreach (lst[i]) begin
      pulse(lst[i]);
      settle();
      if (pend[lst[i] + 16]) begin
        take(lst[i] + 16);
        ret(lst[i] + 16);
      end
    end
    // configurable system priority and software pending
    wr(8'h10, 32'h0010_0000, 1'b1);
    eprio[14] = 3;
    rd_chk("sys_prio", 8'h10, 32'h0010_0000);
    wr(8'h04, 32'h0000_0003, 1'b1);
    pend[14] = 1;
    pend[15] = 1;
    rd_chk("sys_pend", 8'h04, 32'h0000_C000);
    settle();
    take(15);
    ret(15);
    take(14);
    ret(14);
    // fixed priorities beat configurable ones
    pulse(5);
    fire(0);
    pulse(30);
    settle();
    take(2);
    ret(2);
    take(3);
    ret(3);
    take(21);
    ret(21);
    for (int k = 1; k < 7; k++) begin
      fire(k);
      settle();
      lst[0] = win();
      take(lst[0]);
      ret(lst[0]);
    end
    // preemption and equal-priority hold-off
    wr(8'h20, 32'h0000_1335, 1'b1);
    eprio[16] = 7;
    eprio[17] = 5;
    eprio[18] = 5;
    eprio[19] = 3;
    pulse(0);
    pulse(1);
    settle();
    take(17);
    pulse(2);
    settle();
    rd_chk("irq_pend", 8'h08, 32'h0000_0005);
    pulse(3);
    settle();
    take(19);
    ret(19);
    ret(17);
    take(18);
    ret(18);
    take(16);
    ret(16);
    final_report();
  end
endmodule
